//--- rtl/modem_params.svh
`ifndef MODEM_PARAMS_SVH
`define MODEM_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets (word index on the plain register port)
// ----------------------------------------------------------------------
`define OFF_MODEM_CONTROL      3'h0
`define OFF_MODEM_LINE_STATUS  3'h1
`define OFF_SCRATCH_STORAGE    3'h2
`define OFF_ENHANCED_FEATURE   3'h3
`define OFF_IRQ_STATUS         3'h4
`define OFF_IRQ_ENABLE         3'h5
`define OFF_IRQ_CLEAR          3'h6

// ----------------------------------------------------------------------
// modem control register fields
// ----------------------------------------------------------------------
`define MC_DTR_BIT             0
`define MC_RTS_BIT             1
`define MC_AUX_A_BIT           2
`define MC_AUX_B_BIT           3
`define MC_LOOP_BIT            4
`define MC_WRITE_MASK          8'h1f

// ----------------------------------------------------------------------
// enhanced feature register fields
// ----------------------------------------------------------------------
`define EF_AUTO_CTS_BIT        7
`define EF_AUTO_RTS_BIT        6
`define EF_WRITE_MASK          8'hc0

// ----------------------------------------------------------------------
// interrupt status fields: one bit per change event, one for the halt
// ----------------------------------------------------------------------
`define IRQ_CTS_BIT            0
`define IRQ_DSR_BIT            1
`define IRQ_RI_BIT             2
`define IRQ_DCD_BIT            3
`define IRQ_HALT_BIT           4
`define IRQ_MASK               8'h1f

// ----------------------------------------------------------------------
// reset values and timing counts
// ----------------------------------------------------------------------
`define RST_BYTE               8'h00
`define RST_FLAGS              4'h0
`define RST_PINS               4'hf
// two edges fill the synchroniser, a third loads the previous line state
`define PRIME_CYCLES           2'd3

`endif

//--- rtl/modem_pkg.sv
package modem_pkg;

  // transmit gate: run, let the current character drain, halted
  typedef enum logic [1:0]
  {
    TX_RUN   = 2'b00,
    TX_DRAIN = 2'b01,
    TX_HALT  = 2'b11
  } tx_gate_t;

  typedef logic [7:0] byte_t;
  typedef logic [3:0] line_t;

endpackage

//--- rtl/sync_bank.sv
`timescale 1ns/100ps

// two-flop synchroniser for a bank of asynchronous level inputs
module sync_bank #(
  parameter int    WIDTH     = 4,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             nrst,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // a zero-width bank has nothing to synchronise
  if (WIDTH < 1)
  begin
    $error("sync_bank: WIDTH must be at least 1");
  end

  // first stage feeds only the second stage
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q   <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

//--- rtl/modem_status_and_scratch.sv
// How it works
// - status bit 7 is inverted carrier detect, or aux output b in loop-back
// - status bit 6 is inverted ring indicator, or aux output a in loop-back
// - status bit 5 is inverted data set ready, or the dtr control bit in loop-back
// - status bit 4 is inverted clear to send, or the rts control bit in loop-back
// - with auto flow on, clear to send high halts transmit after current char
// - carrier, dsr and cts change flags set on any toggle since last read
// - ring change flag sets only when the ring pin goes from 0 to 1
// - reading the status register clears all four change flags
// - modem status interrupt is raised while any change flag is set
// - eight-bit scratch register returns what was last written, nothing else
// - with auto flow on, transmit resumes once clear to send returns low
// - reset clears change flags; upper status bits read inactive until the synchroniser refills
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
`include "modem_params.svh"

module modem_status_and_scratch #(
  parameter int ADDR_W = 3
) (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                nrst,
  // register port
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire modem_pkg::byte_t    reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output modem_pkg::byte_t         reg_rdata,
  // modem inputs, active low, asynchronous
  input  wire logic                dcd_n,
  input  wire logic                ri_n,
  input  wire logic                dsr_n,
  input  wire logic                cts_n,
  // modem outputs, active low
  output logic                     dtr_n,
  output logic                     rts_n,
  output logic                     aux_output_a_n,
  output logic                     aux_output_b_n,
  // transmitter handshake
  input  wire logic                tx_busy,
  output logic                     tx_halt,
  output logic                     auto_rts_en,
  // interrupts
  output logic                     modem_irq,
  output logic                     irq
);

  import modem_pkg::*;

  // refuse an index too narrow to reach every register
  if (ADDR_W < 3)
  begin
    $error("modem_status_and_scratch: ADDR_W must be at least 3");
  end

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------

  // upper address bits must be zero so aliases never appear
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [2:0] off);
    hit = (a == ADDR_W'(off));
  endfunction

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  byte_t    modem_control_reg_q;
  byte_t    enhanced_feature_reg_q;
  byte_t    scratch_storage_q;
  byte_t    irq_status_q;
  byte_t    irq_status_d;
  byte_t    irq_enable_q;
  byte_t    rdata_q;
  byte_t    rdata_d;
  byte_t    modem_line_status;
  line_t    pin_sync;
  line_t    line_now;
  line_t    line_prev_q;
  line_t    line_change;
  line_t    flags_q;
  line_t    flags_d;
  line_t    flag_set;
  logic [1:0] prime_q;
  logic     primed;
  logic     loop_mode;
  logic     status_read;
  logic     cts_block;
  logic     halt_event;
  tx_gate_t gate_q;
  tx_gate_t gate_d;

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------

  // pins idle high, so the bank resets to the inactive level
  sync_bank #(
    .WIDTH   (4),
    .RST_VAL (`RST_PINS)
  ) u_sync (
    .mclk     (mclk),
    .nrst     (nrst),
    .async_in ({dcd_n, ri_n, dsr_n, cts_n}),
    .sync_out (pin_sync)
  );

  // ----------------------------------------------------------------------
  // live line state
  // ----------------------------------------------------------------------
  assign loop_mode = modem_control_reg_q[`MC_LOOP_BIT];

  // order is {carrier, ring, data set ready, clear to send}
  always_comb
  begin
    if (loop_mode)
    begin
      line_now[3] = modem_control_reg_q[`MC_AUX_B_BIT];
      line_now[2] = modem_control_reg_q[`MC_AUX_A_BIT];
      line_now[1] = modem_control_reg_q[`MC_DTR_BIT];
      line_now[0] = modem_control_reg_q[`MC_RTS_BIT];
    end
    else
    begin
      line_now[3] = ~pin_sync[3];
      line_now[2] = ~pin_sync[2];
      line_now[1] = ~pin_sync[1];
      line_now[0] = ~pin_sync[0];
    end
  end

  // upper half is not stored here; outside loop-back it follows the synchroniser, which reset loads with the inactive level
  assign modem_line_status = {line_now, flags_q};

  // ----------------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------------

  // the synchroniser needs two edges to fill; comparing before then would
  // report the reset value against the real pin as a false change
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      prime_q <= 2'd0;
    else if (prime_q != `PRIME_CYCLES)
      prime_q <= prime_q + 2'd1;
  end

  assign primed = (prime_q == `PRIME_CYCLES);

  // previous line state, compared every cycle
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      line_prev_q <= 4'h0;
    else
      line_prev_q <= line_now;
  end

  assign line_change = line_now ^ line_prev_q;

  // ring only flags the pin going back high, i.e. its status falling
  always_comb
  begin
    flag_set = 4'h0;
    if (primed)
    begin
      flag_set[3] = line_change[3];
      flag_set[2] = line_prev_q[2] & ~line_now[2];
      flag_set[1] = line_change[1];
      flag_set[0] = line_change[0];
    end
  end

  // ----------------------------------------------------------------------
  // change flags
  // ----------------------------------------------------------------------
  assign status_read = reg_rd && hit(reg_addr, `OFF_MODEM_LINE_STATUS);

  // set wins over the read clear so a coincident change is not lost
  always_comb
  begin
    flags_d = flags_q;
    if (status_read)
      flags_d = 4'h0;
    flags_d = flags_d | flag_set;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      flags_q <= `RST_FLAGS;
    else
      flags_q <= flags_d;
  end

  // level, held until software reads the status register
  assign modem_irq = |flags_q;

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------

  // only defined fields are stored; the rest read back as zero
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      modem_control_reg_q <= `RST_BYTE;
    else if (reg_wr && hit(reg_addr, `OFF_MODEM_CONTROL))
      modem_control_reg_q <= reg_wdata & `MC_WRITE_MASK;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      enhanced_feature_reg_q <= `RST_BYTE;
    else if (reg_wr && hit(reg_addr, `OFF_ENHANCED_FEATURE))
      enhanced_feature_reg_q <= reg_wdata & `EF_WRITE_MASK;
  end

  // plain storage, no side effect on any other logic
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      scratch_storage_q <= `RST_BYTE;
    else if (reg_wr && hit(reg_addr, `OFF_SCRATCH_STORAGE))
      scratch_storage_q <= reg_wdata;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      irq_enable_q <= `RST_BYTE;
    else if (reg_wr && hit(reg_addr, `OFF_IRQ_ENABLE))
      irq_enable_q <= reg_wdata & `IRQ_MASK;
  end

  assign auto_rts_en = enhanced_feature_reg_q[`EF_AUTO_RTS_BIT];

  // ----------------------------------------------------------------------
  // modem outputs
  // ----------------------------------------------------------------------

  // in loop-back the pins park inactive; control bits feed status instead
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      dtr_n          <= 1'b1;
      rts_n          <= 1'b1;
      aux_output_a_n <= 1'b1;
      aux_output_b_n <= 1'b1;
    end
    else
    begin
      dtr_n          <= loop_mode | ~modem_control_reg_q[`MC_DTR_BIT];
      rts_n          <= loop_mode | ~modem_control_reg_q[`MC_RTS_BIT];
      aux_output_a_n <= loop_mode | ~modem_control_reg_q[`MC_AUX_A_BIT];
      aux_output_b_n <= loop_mode | ~modem_control_reg_q[`MC_AUX_B_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // transmit gate
  // ----------------------------------------------------------------------

  // clear to send inactive means its status bit is zero
  assign cts_block = enhanced_feature_reg_q[`EF_AUTO_CTS_BIT] & ~line_now[0];

  // the gate never cuts a character: it waits for tx_busy to fall
  always_comb
  begin
    gate_d = gate_q;
    unique case (gate_q)
      TX_RUN:
      begin
        if (cts_block)
          gate_d = tx_busy ? TX_DRAIN : TX_HALT;
      end
      TX_DRAIN:
      begin
        if (!cts_block)
          gate_d = TX_RUN;
        else if (!tx_busy)
          gate_d = TX_HALT;
      end
      TX_HALT:
      begin
        if (!cts_block)
          gate_d = TX_RUN;
      end
      default:
        gate_d = TX_RUN;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      gate_q <= TX_RUN;
    else
      gate_q <= gate_d;
  end

  // the serial engine samples this before starting each character
  assign tx_halt    = (gate_q == TX_HALT) || (gate_q == TX_DRAIN);
  assign halt_event = (gate_d == TX_HALT) && (gate_q != TX_HALT);

  // ----------------------------------------------------------------------
  // interrupt status
  // ----------------------------------------------------------------------

  // write one to clear; a new event in the same cycle keeps its bit
  always_comb
  begin
    irq_status_d = irq_status_q;
    if (reg_wr && hit(reg_addr, `OFF_IRQ_CLEAR))
      irq_status_d = irq_status_d & ~reg_wdata;
    irq_status_d[`IRQ_DCD_BIT]  = irq_status_d[`IRQ_DCD_BIT] | flag_set[3];
    irq_status_d[`IRQ_RI_BIT]   = irq_status_d[`IRQ_RI_BIT]  | flag_set[2];
    irq_status_d[`IRQ_DSR_BIT]  = irq_status_d[`IRQ_DSR_BIT] | flag_set[1];
    irq_status_d[`IRQ_CTS_BIT]  = irq_status_d[`IRQ_CTS_BIT] | flag_set[0];
    irq_status_d[`IRQ_HALT_BIT] = irq_status_d[`IRQ_HALT_BIT] | halt_event;
    irq_status_d = irq_status_d & `IRQ_MASK;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      irq_status_q <= `RST_BYTE;
    else
      irq_status_q <= irq_status_d;
  end

  assign irq = |(irq_status_q & irq_enable_q);

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------

  // unmapped and write-only offsets return zero
  always_comb
  begin
    rdata_d = 8'h00;
    if (reg_rd)
    begin
      if (hit(reg_addr, `OFF_MODEM_CONTROL))
        rdata_d = modem_control_reg_q;
      else if (hit(reg_addr, `OFF_MODEM_LINE_STATUS))
        rdata_d = modem_line_status;
      else if (hit(reg_addr, `OFF_SCRATCH_STORAGE))
        rdata_d = scratch_storage_q;
      else if (hit(reg_addr, `OFF_ENHANCED_FEATURE))
        rdata_d = enhanced_feature_reg_q;
      else if (hit(reg_addr, `OFF_IRQ_STATUS))
        rdata_d = irq_status_q;
      else if (hit(reg_addr, `OFF_IRQ_ENABLE))
        rdata_d = irq_enable_q;
    end
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      rdata_q <= 8'h00;
    else
      rdata_q <= rdata_d;
  end

  assign reg_rdata = rdata_q;

endmodule

//--- tb/modem_peer.sv
`timescale 1ns/100ps

// far-side modem: holds the four active-low status lines
module modem_peer (
  // clock
  input  wire logic mclk,
  // lines toward the device
  output logic      dcd_n,
  output logic      ri_n,
  output logic      dsr_n,
  output logic      cts_n
);
  // lines rest high, as with no modem attached
  initial {dcd_n, ri_n, dsr_n, cts_n} = 4'hf;

  // move the lines just after an edge, then hold them dwell cycles
  task automatic set_lines(input logic [3:0] lv, input int dwell);
    @(posedge mclk);
    {dcd_n, ri_n, dsr_n, cts_n} <= lv;
    repeat (dwell) @(posedge mclk);
  endtask
endmodule

//--- tb/modem_status_and_scratch_asserts.sv
`timescale 1ns/100ps
`include "modem_params.svh"

// pin-level checker; shadows the writable bits so no internal view is needed
module modem_status_and_scratch_asserts #(
  parameter int ADDR_W = 3
) (
  // clock and reset
  input wire logic              mclk,
  input wire logic              nrst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire modem_pkg::byte_t  reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire modem_pkg::byte_t  reg_rdata,
  // modem lines
  input wire logic              dcd_n,
  input wire logic              ri_n,
  input wire logic              dsr_n,
  input wire logic              cts_n,
  input wire logic              dtr_n,
  input wire logic              rts_n,
  input wire logic              aux_output_a_n,
  input wire logic              aux_output_b_n,
  // transmit gate and interrupts
  input wire logic              tx_busy,
  input wire logic              tx_halt,
  input wire logic              auto_rts_en,
  input wire logic              modem_irq,
  input wire logic              irq
);
  import modem_pkg::*;

  byte_t scr_q, mc_q, ef_q, ie_q;
  logic  loop_on, auto_cts, st_rd;

  // shadow copies of the writable registers
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      scr_q <= `RST_BYTE;
      mc_q  <= `RST_BYTE;
      ef_q  <= `RST_BYTE;
      ie_q  <= `RST_BYTE;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `OFF_SCRATCH_STORAGE) scr_q <= reg_wdata;
      if (reg_addr == `OFF_MODEM_CONTROL) mc_q <= reg_wdata & `MC_WRITE_MASK;
      if (reg_addr == `OFF_ENHANCED_FEATURE) ef_q <= reg_wdata & `EF_WRITE_MASK;
      if (reg_addr == `OFF_IRQ_ENABLE) ie_q <= reg_wdata & `IRQ_MASK;
    end

  // decoded helpers
  assign loop_on  = mc_q[`MC_LOOP_BIT];
  assign auto_cts = ef_q[`EF_AUTO_CTS_BIT];
  assign st_rd    = reg_rd && reg_addr == `OFF_MODEM_LINE_STATUS;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  chk_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside its slot");
  chk_scratch_back: assert property (reg_rd && reg_addr == `OFF_SCRATCH_STORAGE
    |=> reg_rdata == $past(scr_q)) else $error("scratch read differs from last write");
  chk_unmapped_zero: assert property (reg_rd && (reg_addr == 3'h7
    || reg_addr == `OFF_IRQ_CLEAR) |=> reg_rdata == 8'h00) else $error("unmapped read not 0");
  chk_flag_report: assert property (st_rd |=> (|reg_rdata[3:0]) == $past(modem_irq))
    else $error("reported flags disagree with interrupt");
  chk_flag_hold: assert property (modem_irq && !st_rd |=> modem_irq)
    else $error("change flags dropped without a status read");
  chk_irq_masked: assert property (ie_q == 8'h00 |-> !irq)
    else $error("interrupt high with nothing enabled");
  chk_halt_needs_auto: assert property (!auto_cts && !$past(auto_cts) |-> !tx_halt)
    else $error("transmit halted without flow control");
  chk_halt_on_cts: assert property ((auto_cts && !loop_on && cts_n && !tx_busy) [*5]
    |-> tx_halt) else $error("transmit not halted");
  chk_resume_cts: assert property ((!cts_n && !loop_on) [*5] |-> !tx_halt)
    else $error("transmit not resumed");
  chk_loop_quiet: assert property (loop_on && $past(loop_on)
    |-> dtr_n && rts_n && aux_output_a_n && aux_output_b_n) else $error("outputs active in loop");
  chk_ctrl_drive: assert property (!loop_on && $stable(mc_q) |-> dtr_n == !mc_q[0]
    && rts_n == !mc_q[1] && aux_output_a_n == !mc_q[2] && aux_output_b_n == !mc_q[3])
    else $error("modem outputs differ from control bits");

  cov_flag_read: cover property (st_rd && modem_irq);
  cov_halt: cover property ($rose(tx_halt));
  cov_irq: cover property ($rose(irq));
endmodule

bind modem_status_and_scratch modem_status_and_scratch_asserts #(.ADDR_W(ADDR_W)) u_chk (
  .mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .dcd_n, .ri_n, .dsr_n,
  .cts_n, .dtr_n, .rts_n, .aux_output_a_n, .aux_output_b_n, .tx_busy, .tx_halt,
  .auto_rts_en, .modem_irq, .irq
);

//--- tb/testbench.sv
`timescale 1ns/100ps
`include "modem_params.svh"

module testbench;
  import modem_pkg::*;

  logic       mclk, nrst, reg_wr, reg_rd, tx_busy;
  logic [2:0] reg_addr;
  byte_t      reg_wdata, reg_rdata, rv;
  logic       dcd_n, ri_n, dsr_n, cts_n, dtr_n, rts_n, aux_output_a_n, aux_output_b_n;
  logic       tx_halt, auto_rts_en, modem_irq, irq;
  int         num_errors, comparisons;

  // 200 mhz clock
  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;

  modem_status_and_scratch #(.ADDR_W(3)) uut (
    .mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .dcd_n, .ri_n,
    .dsr_n, .cts_n, .dtr_n, .rts_n, .aux_output_a_n, .aux_output_b_n, .tx_busy, .tx_halt,
    .auto_rts_en, .modem_irq, .irq
  );

  modem_peer peer (.mclk, .dcd_n, .ri_n, .dsr_n, .cts_n);

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input byte_t got, input byte_t exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one-cycle strobes; the trailing #1 lets the taking edge settle
  task automatic wr(input logic [2:0] a, input byte_t d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask

  // bounded wait; running out shows up as a failed compare
  task automatic wait_halt(input logic lv);
    int n;
    n = 0;
    while (tx_halt !== lv && n < 40)
    begin
      @(posedge mclk);
      #1 n++;
    end
    check({7'h0, tx_halt}, {7'h0, lv});
    if (n == 40)
      wrap_up();
  endtask

  task automatic wrap_up();
    $display("checks=%0d errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    wr(`OFF_SCRATCH_STORAGE, 8'ha5);
    rd(`OFF_SCRATCH_STORAGE);
    check(rv, 8'ha5);
    wr(`OFF_MODEM_LINE_STATUS, 8'h0f);
    wr(`OFF_SCRATCH_STORAGE, 8'h5a);
    rd(3'h7);
    check(rv, 8'h00);
    rd(`OFF_SCRATCH_STORAGE);
    check(rv, 8'h5a);
    $display("t_regs done");
  endtask

  task automatic t_live();
    rd(`OFF_MODEM_LINE_STATUS);
    check(rv, 8'h00);
    peer.set_lines(4'b0101, 5);
    check({7'h0, modem_irq}, 8'h01);
    rd(`OFF_MODEM_LINE_STATUS);
    check(rv, 8'haa);
    rd(`OFF_MODEM_LINE_STATUS);
    check(rv, 8'ha0);
    check({7'h0, modem_irq}, 8'h00);
    $display("t_live done");
  endtask

  // ring falls (no flag) then rises (flag); cts toggles both ways
  task automatic t_ring();
    peer.set_lines(4'b0000, 5);
    rd(`OFF_MODEM_LINE_STATUS);
    check(rv, 8'hf1);
    wr(`OFF_IRQ_ENABLE, 8'h04);
    peer.set_lines(4'b0101, 5);
    check({7'h0, irq}, 8'h01);
    rd(`OFF_IRQ_STATUS);
    check(rv, 8'h0f);
    wr(`OFF_IRQ_CLEAR, 8'h04);
    check({7'h0, irq}, 8'h00);
    rd(`OFF_IRQ_STATUS);
    check(rv, 8'h0b);
    rd(`OFF_MODEM_LINE_STATUS);
    check(rv, 8'ha5);
    $display("t_ring done");
  endtask

  // flags may fire on entering loop-back, so the first two status reads compare only the live half
  task automatic t_loop();
    wr(`OFF_MODEM_CONTROL, 8'h1b);
    repeat (3) @(posedge mclk);
    rd(`OFF_MODEM_LINE_STATUS);
    check(rv & 8'hf0, 8'hb0);
    rd(`OFF_MODEM_CONTROL);
    check(rv, 8'h1b);
    check({4'h0, dtr_n, rts_n, aux_output_a_n, aux_output_b_n}, 8'h0f);
    wr(`OFF_MODEM_CONTROL, 8'h14);
    repeat (3) @(posedge mclk);
    rd(`OFF_MODEM_LINE_STATUS);
    check(rv & 8'hf0, 8'h40);
    // a change landing in the same cycle as a status read must stay flagged
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= `OFF_MODEM_CONTROL;
    reg_wdata <= 8'h15;
    @(posedge mclk);
    reg_wr   <= 1'b0;
    reg_rd   <= 1'b1;
    reg_addr <= `OFF_MODEM_LINE_STATUS;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, 8'h60);
    rd(`OFF_MODEM_LINE_STATUS);
    check(rv, 8'h62);
    wr(`OFF_MODEM_CONTROL, 8'h0b);
    repeat (2) @(posedge mclk);
    check({4'h0, dtr_n, rts_n, aux_output_a_n, aux_output_b_n}, 8'h02);
    wr(`OFF_MODEM_CONTROL, 8'h00);
    rd(`OFF_MODEM_LINE_STATUS);
    rd(`OFF_MODEM_LINE_STATUS);
    $display("t_loop done");
  endtask

  // clear to send is high here: halt must wait for the busy character
  task automatic t_flow();
    wr(`OFF_IRQ_CLEAR, 8'hff);
    wr(`OFF_IRQ_ENABLE, 8'h10);
    @(posedge mclk);
    tx_busy <= 1'b1;
    wr(`OFF_ENHANCED_FEATURE, 8'h80);
    wait_halt(1'b1);
    repeat (3) @(posedge mclk);
    #1 check({7'h0, irq}, 8'h00);
    @(posedge mclk);
    tx_busy <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 check({7'h0, irq}, 8'h01);
    wr(`OFF_IRQ_CLEAR, 8'h10);
    peer.set_lines(4'b0100, 5);
    wait_halt(1'b0);
    wr(`OFF_ENHANCED_FEATURE, 8'h40);
    check({7'h0, auto_rts_en}, 8'h01);
    wr(`OFF_ENHANCED_FEATURE, 8'h00);
    $display("t_flow done");
  endtask

  // lines held active through a mid-run reset: no false change once it fills
  task automatic t_reset();
    peer.set_lines(4'b0000, 2);
    nrst <= 1'b0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    repeat (6) @(posedge mclk);
    rd(`OFF_MODEM_LINE_STATUS);
    check(rv, 8'hf0);
    check({7'h0, modem_irq}, 8'h00);
    $display("t_reset done");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    nrst        = 1'b0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    reg_addr    = 3'h0;
    reg_wdata   = 8'h00;
    tx_busy     = 1'b0;
    num_errors  = 0;
    comparisons = 0;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    t_regs();
    t_live();
    t_ring();
    t_loop();
    t_flow();
    t_reset();
    wrap_up();
  end
endmodule
